/* File: kpi_keypad.sv */
`timescale 1ns/1ps
module kpi_keypad (
  input wire logic hclk,
  input wire logic [7:0] press,
  input wire logic [7:0] pins_out,
  input wire logic [7:0] pins_oe,
  input wire logic [7:0] pullup_en,
  output logic [7:0] pins_in
);
  // Undriven, unpulled pins float to a changing pattern
  logic [7:0] float_r = 8'h5A;
  always_ff @(posedge hclk) begin
    float_r <= ~float_r;
  end
  assign pins_in = (pins_oe & pins_out) |
    (~pins_oe & ~press & (pullup_en | float_r));
endmodule

/* File: kpi_pkg.sv */
// Function
// - Eight pin inputs, own enables, one mask
// - Pin enable also switches on pullup
// - Latch when enabled pins fall after all high
// - Edge mode ignores edge while another pin low
// - Level mode requests while any enabled pin low
// - Select bit picks edge or edge-plus-level
// - Level mode clears after acknowledge and pins high
// - Vector fetch or acknowledge write clears request
// - New falling edge after acknowledge latches again
// - Serviced request uses vector at FFE0/FFE1
// - Edge mode acknowledge clears request at once
// - Reset clears request and select bit
// - Pending flag ignores the mask
// - Pin enable forces input over direction bit; data register reads still follow the direction bit
// - Active in wait/stop, unmasked request wakes
// - Break state ignores acknowledge unless enabled
// - Acknowledge bit write-only, reads zero
// - Reset clears all pin enable bits
package kpi_pkg;

  localparam logic [7:0] KEYPAD_STATUS_CONTROL_REG = 8'h00;
  localparam logic [7:0] KEYPAD_ENABLE_REG = 8'h04;
  localparam logic [7:0] PORT_A_DIRECTION_REG = 8'h08;
  localparam logic [7:0] PORT_A_DATA_REG = 8'h0C;
  localparam logic [7:0] BREAK_FLAG_CONTROL_REG = 8'h10;

  localparam int MODE_BIT = 0;
  localparam int MASK_BIT = 1;
  localparam int ACK_BIT = 2;
  localparam int PEND_BIT = 3;
  localparam int BREAK_CLEAR_ENABLE_BIT = 0;

  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] DIRECTION_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] SYNC_RESET = 8'hFF;

  localparam logic [15:0] KEYPAD_VECTOR_ADDR = 16'hFFE0;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_WRITE,
    PH_READ_WAIT,
    PH_READ_DONE
  } kpi_phase_t;

endpackage

/* File: kpi_top.sv */
// Design decisions made here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module kpi_top #(
  parameter int PINS = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [PINS-1:0] port_a_pins_in,
  output logic [PINS-1:0] port_a_pins_out,
  output logic [PINS-1:0] port_a_pins_oe,
  output logic [PINS-1:0] port_a_pullup_en,
  input wire logic vector_fetch,
  input wire logic break_state,
  output logic irq_request,
  output logic wake_request,
  output logic keypad_pending_flag,
  output logic [15:0] irq_vector_addr
);

  typedef struct packed {
    kpi_pkg::kpi_phase_t phase;
    logic [7:0] addr;
    logic [31:0] rdata;
    logic trigger_sensitivity_select;
    logic keypad_request_mask;
    logic break_clear_enable;
    logic [PINS-1:0] pin_irq_enable_bits;
    logic [PINS-1:0] direction;
    logic [PINS-1:0] dout;
    logic [PINS-1:0] sync1;
    logic [PINS-1:0] sync2;
    logic [PINS-1:0] sync3;
    logic [PINS-1:0] filt;
    logic all_high_prev;
    logic latch;
    logic ack_seen;
  } kpi_state_t;

  kpi_state_t st_r;
  kpi_state_t st_nxt;

  logic addr_phase;
  logic sw_ack;
  logic ack;
  logic any_low;
  logic all_high;
  logic fall_edge;
  logic [PINS-1:0] pin_level;
  logic [31:0] rd_mux;

  always_comb begin
    all_high = &(st_r.filt | ~st_r.pin_irq_enable_bits);
    any_low = ~all_high;
    fall_edge = st_r.all_high_prev & any_low;
  end

  assign addr_phase = hsel & hready & (htrans == kpi_pkg::HTRANS_NONSEQ);

  assign sw_ack = (st_r.phase == kpi_pkg::PH_WRITE)
    & (st_r.addr == kpi_pkg::KEYPAD_STATUS_CONTROL_REG)
    & hwdata[kpi_pkg::ACK_BIT]
    & (~break_state | st_r.break_clear_enable);

  assign ack = vector_fetch | sw_ack;

  // Readable pin level needs direction 0
  assign pin_level = (st_r.filt & ~st_r.direction)
    | (st_r.dout & st_r.direction);

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (st_r.addr)
      kpi_pkg::KEYPAD_STATUS_CONTROL_REG: begin
        rd_mux[kpi_pkg::PEND_BIT] = st_r.latch;
        rd_mux[kpi_pkg::MASK_BIT] = st_r.keypad_request_mask;
        rd_mux[kpi_pkg::MODE_BIT] = st_r.trigger_sensitivity_select;
      end
      kpi_pkg::KEYPAD_ENABLE_REG: begin
        rd_mux[PINS-1:0] = st_r.pin_irq_enable_bits;
      end
      kpi_pkg::PORT_A_DIRECTION_REG: begin
        rd_mux[PINS-1:0] = st_r.direction;
      end
      kpi_pkg::PORT_A_DATA_REG: begin
        rd_mux[PINS-1:0] = pin_level;
      end
      kpi_pkg::BREAK_FLAG_CONTROL_REG: begin
        rd_mux[kpi_pkg::BREAK_CLEAR_ENABLE_BIT] = st_r.break_clear_enable;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.sync1 = port_a_pins_in;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.sync3 = st_r.sync2;
    for (int i = 0; i < PINS; i++) begin
      if (st_r.sync2[i] == st_r.sync3[i]) begin
        st_nxt.filt[i] = st_r.sync3[i];
      end
    end
    st_nxt.all_high_prev = all_high;

    unique case (st_r.phase)
      kpi_pkg::PH_IDLE: begin
      end
      kpi_pkg::PH_WRITE: begin
        unique case (st_r.addr)
          kpi_pkg::KEYPAD_STATUS_CONTROL_REG: begin
            st_nxt.trigger_sensitivity_select = hwdata[kpi_pkg::MODE_BIT];
            st_nxt.keypad_request_mask = hwdata[kpi_pkg::MASK_BIT];
          end
          kpi_pkg::KEYPAD_ENABLE_REG: begin
            st_nxt.pin_irq_enable_bits = hwdata[PINS-1:0];
          end
          kpi_pkg::PORT_A_DIRECTION_REG: begin
            st_nxt.direction = hwdata[PINS-1:0];
          end
          kpi_pkg::PORT_A_DATA_REG: begin
            st_nxt.dout = hwdata[PINS-1:0];
          end
          kpi_pkg::BREAK_FLAG_CONTROL_REG: begin
            st_nxt.break_clear_enable = hwdata[kpi_pkg::BREAK_CLEAR_ENABLE_BIT];
          end
          default: begin
          end
        endcase
      end
      kpi_pkg::PH_READ_WAIT: begin
        st_nxt.rdata = rd_mux;
      end
      kpi_pkg::PH_READ_DONE: begin
      end
    endcase

    if (st_r.phase == kpi_pkg::PH_READ_WAIT) begin
      st_nxt.phase = kpi_pkg::PH_READ_DONE;
    end else if (addr_phase) begin
      st_nxt.addr = {haddr[7:2], 2'b00};
      st_nxt.phase = hwrite ? kpi_pkg::PH_WRITE : kpi_pkg::PH_READ_WAIT;
    end else begin
      st_nxt.phase = kpi_pkg::PH_IDLE;
    end

    if (!st_r.trigger_sensitivity_select) begin
      st_nxt.ack_seen = 1'b0;
      if (ack) begin
        st_nxt.latch = 1'b0;
      end
      // Edge after all high sets, wins over clear
      if (fall_edge) begin
        st_nxt.latch = 1'b1;
      end
    end else begin
      st_nxt.latch = st_r.latch | fall_edge | any_low;
      // Clear needs acknowledge and all high
      st_nxt.ack_seen = st_r.ack_seen | (ack & st_r.latch);
      if (st_nxt.ack_seen && all_high) begin
        st_nxt.latch = 1'b0;
        st_nxt.ack_seen = 1'b0;
      end
    end
  end

  // Reset clears request, select and enables
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r.phase <= kpi_pkg::PH_IDLE;
      st_r.addr <= 8'h00;
      st_r.rdata <= 32'h0000_0000;
      st_r.trigger_sensitivity_select <= 1'b0;
      st_r.keypad_request_mask <= 1'b0;
      st_r.break_clear_enable <= 1'b0;
      st_r.pin_irq_enable_bits <= kpi_pkg::ENABLE_RESET;
      st_r.direction <= kpi_pkg::DIRECTION_RESET;
      st_r.dout <= kpi_pkg::DATA_RESET;
      st_r.sync1 <= kpi_pkg::SYNC_RESET;
      st_r.sync2 <= kpi_pkg::SYNC_RESET;
      st_r.sync3 <= kpi_pkg::SYNC_RESET;
      st_r.filt <= kpi_pkg::SYNC_RESET;
      st_r.all_high_prev <= 1'b1;
      st_r.latch <= 1'b0;
      st_r.ack_seen <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hreadyout = (st_r.phase != kpi_pkg::PH_READ_WAIT);
  assign hresp = 1'b0;
  assign hrdata = st_r.rdata;

  assign port_a_pins_out = st_r.dout;
  assign port_a_pins_oe = st_r.direction & ~st_r.pin_irq_enable_bits;
  assign port_a_pullup_en = st_r.pin_irq_enable_bits;
  assign keypad_pending_flag = st_r.latch;
  assign irq_request = st_r.latch & ~st_r.keypad_request_mask;
  // Unmasked request wakes from wait or stop
  assign wake_request = st_r.latch & ~st_r.keypad_request_mask;
  assign irq_vector_addr = kpi_pkg::KEYPAD_VECTOR_ADDR;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_edge_sets_latch: assert property (
    fall_edge |=> st_r.latch)
    else $error("falling edge did not latch request");

  a_edge_ack_clear: assert property (
    !st_r.trigger_sensitivity_select && ack && !fall_edge
    |=> !st_r.latch)
    else $error("edge mode acknowledge did not clear");

  a_level_hold_low: assert property (
    st_r.trigger_sensitivity_select && any_low
    && $stable(st_r.trigger_sensitivity_select)
    |=> st_r.latch)
    else $error("level mode dropped request while pin low");

  a_break_protect: assert property (
    break_state && !st_r.break_clear_enable && !vector_fetch
    && st_r.latch && !st_r.trigger_sensitivity_select
    |=> st_r.latch)
    else $error("acknowledge cleared latch during break");

  a_pend_unmasked: assert property (
    $rose(keypad_pending_flag) && !st_r.keypad_request_mask
    |-> irq_request && wake_request)
    else $error("unmasked pending did not raise request");

  a_enable_input: assert property (
    (port_a_pins_oe & st_r.pin_irq_enable_bits) == '0)
    else $error("enabled pin driven as output");

  a_pullup_write: assert property (
    st_r.phase == kpi_pkg::PH_WRITE
    && st_r.addr == kpi_pkg::KEYPAD_ENABLE_REG
    |=> port_a_pullup_en == $past(hwdata[PINS-1:0]))
    else $error("pullups do not follow enable write");

  a_ack_reads_zero: assert property (
    st_r.phase == kpi_pkg::PH_READ_WAIT
    ##1 st_r.addr == kpi_pkg::KEYPAD_STATUS_CONTROL_REG
    |-> hrdata[kpi_pkg::ACK_BIT] == 1'b0)
    else $error("acknowledge bit read back nonzero");

  a_read_wait: assert property (
    st_r.phase == kpi_pkg::PH_READ_WAIT |-> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

  a_edge_blocked: assert property (
    !st_r.trigger_sensitivity_select && !st_r.all_high_prev
    && !st_r.latch |=> !st_r.latch)
    else $error("edge latched while enabled pin low");

  a_edge_after_ack: assert property (
    ack && fall_edge |=> st_r.latch)
    else $error("edge after acknowledge not latched");

  a_vector_clear: assert property (
    vector_fetch && !st_r.trigger_sensitivity_select && !fall_edge
    |=> !st_r.latch)
    else $error("vector fetch did not clear request");

  a_level_wait_ack: assert property (
    st_r.trigger_sensitivity_select && st_r.latch
    && !st_r.ack_seen && !ack |=> st_r.latch)
    else $error("level request cleared without acknowledge");

  a_level_release: assert property (
    st_r.trigger_sensitivity_select && all_high
    && (st_r.ack_seen || (ack && st_r.latch)) |=> !st_r.latch)
    else $error("level request held after acknowledge and release");

  a_mode_write: assert property (
    st_r.phase == kpi_pkg::PH_WRITE
    && st_r.addr == kpi_pkg::KEYPAD_STATUS_CONTROL_REG
    |=> st_r.trigger_sensitivity_select
    == $past(hwdata[kpi_pkg::MODE_BIT]))
    else $error("sensitivity select does not follow write");

  a_break_clear: assert property (
    break_state && st_r.break_clear_enable
    && st_r.phase == kpi_pkg::PH_WRITE
    && st_r.addr == kpi_pkg::KEYPAD_STATUS_CONTROL_REG
    && hwdata[kpi_pkg::ACK_BIT] && !st_r.trigger_sensitivity_select
    && !fall_edge |=> !st_r.latch)
    else $error("enabled break acknowledge did not clear");

  a_filter_agree: assert property (
    st_r.sync2 == st_r.sync3 |=> st_r.filt == $past(st_r.sync3))
    else $error("filtered pins do not follow agreeing stages");

  a_mask_hides: assert property (
    st_r.keypad_request_mask |-> !irq_request && !wake_request)
    else $error("masked request reached processor");

  a_reset_clear: assert property (
    disable iff (1'b0)
    !hresetn |-> !st_r.latch && !st_r.trigger_sensitivity_select)
    else $error("reset left request or select set");

  a_reset_enables: assert property (
    disable iff (1'b0)
    !hresetn |-> st_r.pin_irq_enable_bits == '0)
    else $error("reset left pin enables set");

  c_edge_latch: cover property (
    !st_r.trigger_sensitivity_select && fall_edge ##1 irq_request);
  c_level_ack: cover property (
    st_r.trigger_sensitivity_select && st_r.ack_seen && any_low
    ##[1:50] !st_r.latch);
  c_break_block: cover property (
    break_state && !st_r.break_clear_enable && st_r.phase
    == kpi_pkg::PH_WRITE && hwdata[kpi_pkg::ACK_BIT] && st_r.latch);
  c_vector_clear: cover property (
    vector_fetch && st_r.latch ##1 !st_r.latch);

endmodule

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
  logic hclk, hresetn, hsel, hwrite, vector_fetch, break_state;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [7:0] press, pins_in, pins_out, pins_oe, pullup_en;
  logic hreadyout, hresp, irq_request, wake_request, keypad_pending_flag;
  logic [15:0] irq_vector_addr;
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  kpi_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .port_a_pins_in(pins_in),
    .port_a_pins_out(pins_out), .port_a_pins_oe(pins_oe),
    .port_a_pullup_en(pullup_en), .vector_fetch(vector_fetch),
    .break_state(break_state), .irq_request(irq_request),
    .wake_request(wake_request), .keypad_pending_flag(keypad_pending_flag),
    .irq_vector_addr(irq_vector_addr));
  kpi_keypad kp_u (.hclk(hclk), .press(press), .pins_out(pins_out),
    .pins_oe(pins_oe), .pullup_en(pullup_en), .pins_in(pins_in));
  task automatic report_and_stop();
    if (n_errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chkp(input logic e);
    chk({31'h0, keypad_pending_flag}, {31'h0, e});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= kpi_pkg::HTRANS_NONSEQ;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic vf();
    vector_fetch <= 1'b1;
    @(posedge hclk);
    vector_fetch <= 1'b0;
    tick(2);
  endtask
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    vector_fetch = 1'b0;
    break_state = 1'b0;
    press = 8'h00;
    tick(5);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h20, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    wr(8'h00, 32'h2);
    wr(8'h04, 32'h3);
    tick(1);
    chk({24'h0, pullup_en}, 32'h3);
    tick(8);
    wr(8'h00, 32'h6);
    wr(8'h00, 32'h0);
    tick(8);
    chkp(1'b0);
    press <= 8'h01;
    tick(8);
    chk({31'h0, irq_request}, 32'h1);
    chk({31'h0, wake_request}, 32'h1);
    chkp(1'b1);
    chk({16'h0, irq_vector_addr}, 32'hFFE0);
    wr(8'h00, 32'h2);
    rd(8'h00, 32'hA);
    chk({31'h0, irq_request}, 32'h0);
    wr(8'h00, 32'h4);
    tick(2);
    chkp(1'b0);
    press <= 8'h03;
    tick(8);
    chkp(1'b0);
    press <= 8'h00;
    tick(8);
    press <= 8'h02;
    tick(8);
    chkp(1'b1);
    vf();
    chkp(1'b0);
    wr(8'h00, 32'h1);
    press <= 8'h01;
    tick(8);
    wr(8'h00, 32'h5);
    tick(2);
    chkp(1'b1);
    press <= 8'h00;
    tick(8);
    chkp(1'b0);
    press <= 8'h02;
    tick(8);
    press <= 8'h00;
    tick(8);
    chkp(1'b1);
    vf();
    chkp(1'b0);
    wr(8'h00, 32'h0);
    break_state <= 1'b1;
    press <= 8'h01;
    tick(8);
    wr(8'h00, 32'h4);
    tick(2);
    chkp(1'b1);
    wr(8'h10, 32'h1);
    wr(8'h00, 32'h4);
    tick(2);
    chkp(1'b0);
    break_state <= 1'b0;
    press <= 8'h00;
    tick(8);
    chkp(1'b0);
    wr(8'h08, 32'hFF);
    wr(8'h0C, 32'hF5);
    tick(8);
    chk({24'h0, pins_out}, 32'hF5);
    wr(8'h04, 32'hF3);
    tick(2);
    chkp(1'b0);
    wr(8'h08, 32'h0F);
    tick(8);
    chk({24'h0, pins_oe}, 32'h0C);
    rd(8'h0C, 32'hF5);
    wr(8'h00, 32'h1);
    press <= 8'h10;
    tick(8);
    chkp(1'b1);
    hresetn <= 1'b0;
    tick(2);
    hresetn <= 1'b1;
    tick(2);
    chkp(1'b0);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    report_and_stop();
  end
endmodule
